// ===== shared/fdhs_pkg.sv
package fdhs_pkg;

  // Clock and bit cell timing
  localparam int CLOCK_NS = 10;
  localparam int SD_CELL_NS = 4000;
  localparam int DD_CELL_NS = 2000;
  localparam int GATE_LEAD_NS = 2000;
  localparam int TYPE1_NS = 1000;
  localparam int SD_HALF_CYCLES = (SD_CELL_NS / 2) / CLOCK_NS;
  localparam int DD_HALF_CYCLES = (DD_CELL_NS / 2) / CLOCK_NS;
  localparam int GATE_LEAD_CYCLES = (GATE_LEAD_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int TYPE1_CYCLES = (TYPE1_NS + CLOCK_NS - 1) / CLOCK_NS;

  // Register select codes
  localparam logic [1:0] SEL_STATUS_CMD = 2'h0;
  localparam logic [1:0] SEL_TRACK = 2'h1;
  localparam logic [1:0] SEL_SECTOR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;

  // Values after reset
  localparam logic [7:0] CMD_RESET = 8'h03;
  localparam logic [7:0] SECTOR_RESET = 8'h01;

  // Head position band for the outer-track indicator
  localparam logic [7:0] OUTER_TRACK_FIRST = 8'h2C;
  localparam logic [7:0] OUTER_TRACK_LAST = 8'h4C;

  // Byte counts
  localparam int SECTOR_BYTES = 256;
  localparam int ADDRESS_BYTES = 6;

  // Status bit positions
  localparam int ST_NOT_READY = 7;
  localparam int ST_WRITE_PROT = 6;
  localparam int ST_WRITE_FAULT = 5;
  localparam int ST_LOST_DATA = 2;
  localparam int ST_TRACK_ZERO = 2;
  localparam int ST_INDEX = 1;
  localparam int ST_DATA_REQ = 1;
  localparam int ST_BUSY = 0;

  // Command classes decoded from the command byte
  typedef enum logic [2:0] {
    K_TYPE1 = 3'h0,
    K_READ_SECTOR = 3'h1,
    K_WRITE_SECTOR = 3'h2,
    K_READ_ADDRESS = 3'h3,
    K_READ_TRACK = 3'h4,
    K_WRITE_TRACK = 3'h5,
    K_FORCE_INT = 3'h6
  } fdhs_kind_t;

  // Main sequencer states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SEEK = 6'h02,
    S_READ = 6'h04,
    S_GATE = 6'h08,
    S_WRITE = 6'h10
  } fdhs_state_e_t;

endpackage

// ===== shared/fdhs_stream_if.sv
`timescale 1ns/1ps
interface fdhs_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== verilog/fdhs_fifo.sv
`timescale 1ns/1ps
module fdhs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  fdhs_stream_if.snk s_in,
  fdhs_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("fdhs_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fdhs_fifo_state_t;

  fdhs_fifo_state_t s_reg;
  fdhs_fifo_state_t s_next;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign s_in.ready = (s_reg.count != (AW + 1)'(DEPTH));
  assign s_out.valid = (s_reg.count != '0);
  assign s_out.data = s_reg.mem[s_reg.rd_ptr];
  assign push = s_in.valid & s_in.ready;
  assign pop = s_out.valid & s_out.ready;

  // Next state; push and pop in one cycle leave the count unchanged
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = s_in.data;
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 1'b1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 1'b1;
    end
    if (!i_resetn) begin
      s_next = '0;
    end
  end

  always_ff @(posedge i_clock) begin
    s_reg <= s_next;
  end
endmodule

// ===== verilog/fdhs_top.sv
`timescale 1ns/1ps
module fdhs_top #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_rd_strobe,
  input wire logic i_wr_strobe,
  input wire logic [1:0] i_reg_sel,
  input wire logic [7:0] i_host_wdata,
  output logic [7:0] o_host_rdata,
  output logic o_data_request,
  output logic o_interrupt_request,
  output logic o_outer_track_indicator,
  output logic o_write_gate,
  output logic o_write_pulse_out,
  input wire logic i_ready,
  input wire logic i_fault_in_vfo_enable_n,
  output logic o_fault_in_vfo_enable_n,
  output logic o_fault_in_vfo_enable_oe_n,
  input wire logic i_track_zero_sense_n,
  input wire logic i_index_hole_sense_n,
  input wire logic i_write_protect_sense_n,
  input wire logic i_density_select,
  input wire logic i_read_bit_strobe,
  input wire logic i_read_bit
);
  import fdhs_pkg::*;

  typedef struct packed {
    fdhs_state_e_t state;
    logic [7:0] cmd;
    logic [7:0] track;
    logic [7:0] sector;
    logic [7:0] data;
    logic data_full;
    logic rd_mode;
    logic type1_last;
    logic st_wp;
    logic st_wf;
    logic st_lost;
    logic irq;
    logic drq;
    logic otk;
    logic gate;
    logic pulse;
    logic vfo_oe_n;
    logic [8:0] bytes;
    logic [8:0] timer;
    logic phase;
    logic [7:0] shift;
    logic [2:0] bitcnt;
    logic sh_valid;
    logic prev_bit;
    logic idx_prev;
    logic [7:0] rdata;
    logic [7:0] asm_shift;
    logic [2:0] asm_cnt;
    logic push_valid;
    logic [7:0] push_data;
  } fdhs_state_t;

  fdhs_state_t s_reg;
  fdhs_state_t s_next;
  fdhs_stream_if #(.WIDTH(8)) fifo_in ();
  fdhs_stream_if #(.WIDTH(8)) fifo_out ();

  ////////////////////////////////////////////////////////////////////////////
  // Command decoding, used at start and for status layout

  function automatic fdhs_kind_t cmd_kind(input logic [7:0] c);
    if (!c[7]) begin
      cmd_kind = K_TYPE1;
    end else if (c[6:4] == 3'h0) begin
      cmd_kind = K_READ_SECTOR;
    end else if (c[6:4] == 3'h1) begin
      cmd_kind = K_WRITE_SECTOR;
    end else if (c[6:4] == 3'h4) begin
      cmd_kind = K_READ_ADDRESS;
    end else if (c[6:4] == 3'h5) begin
      cmd_kind = K_FORCE_INT;
    end else if (c[6:4] == 3'h6) begin
      cmd_kind = K_READ_TRACK;
    end else begin
      cmd_kind = K_WRITE_TRACK;
    end
  endfunction

  function automatic logic [7:0] status_of(input fdhs_state_t s,
                                           input logic ready_in,
                                           input logic tz_n,
                                           input logic idx_n);
    logic [7:0] v;
    v = 8'h00;
    v[ST_NOT_READY] = !ready_in;
    v[ST_BUSY] = (s.state != S_IDLE);
    if (s.type1_last) begin
      v[ST_WRITE_PROT] = !i_write_protect_sense_n;
      v[ST_TRACK_ZERO] = !tz_n;
      v[ST_INDEX] = !idx_n;
    end else begin
      v[ST_WRITE_PROT] = s.st_wp;
      v[ST_WRITE_FAULT] = s.st_wf;
      v[ST_LOST_DATA] = s.st_lost;
      v[ST_DATA_REQ] = s.drq;
    end
    status_of = v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // FIFO hookup: host byte to serializer on writes, assembler to host on reads

  assign fifo_in.valid = s_reg.rd_mode ? s_reg.push_valid :
                         (s_reg.data_full && s_reg.state != S_IDLE);
  assign fifo_in.data = s_reg.rd_mode ? s_reg.push_data : s_reg.data;
  assign fifo_out.ready = s_reg.rd_mode ? !s_reg.data_full :
                          (s_reg.state == S_WRITE && !s_reg.sh_valid);

  fdhs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .s_in(fifo_in.snk),
    .s_out(fifo_out.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, register file and serial paths

  always_comb begin
    logic done;
    logic host_cmd;
    logic [8:0] half;
    logic [8:0] target;
    logic idx_edge;
    fdhs_kind_t k;
    done = 1'b0;
    host_cmd = i_wr_strobe && i_reg_sel == SEL_STATUS_CMD;
    half = i_density_select ? 9'(SD_HALF_CYCLES) : 9'(DD_HALF_CYCLES);
    k = cmd_kind(s_reg.cmd);
    target = (k == K_READ_ADDRESS) ? 9'(ADDRESS_BYTES) : 9'(SECTOR_BYTES);
    idx_edge = s_reg.idx_prev && !i_index_hole_sense_n;
    s_next = s_reg;
    s_next.pulse = 1'b0;
    s_next.idx_prev = i_index_hole_sense_n;

    // Host register access
    if (i_rd_strobe) begin
      unique case (i_reg_sel)
        SEL_STATUS_CMD: s_next.rdata = status_of(s_reg, i_ready,
                          i_track_zero_sense_n, i_index_hole_sense_n);
        SEL_TRACK: s_next.rdata = s_reg.track;
        SEL_SECTOR: s_next.rdata = s_reg.sector;
        SEL_DATA: s_next.rdata = s_reg.data;
      endcase
      if (i_reg_sel == SEL_STATUS_CMD) begin
        s_next.irq = 1'b0;
      end
      if (i_reg_sel == SEL_DATA && s_reg.rd_mode) begin
        s_next.data_full = 1'b0;
      end
    end
    if (i_wr_strobe) begin
      unique case (i_reg_sel)
        SEL_STATUS_CMD: s_next.irq = 1'b0;
        SEL_TRACK: s_next.track = i_host_wdata;
        SEL_SECTOR: s_next.sector = i_host_wdata;
        SEL_DATA: begin
          s_next.data = i_host_wdata;
          s_next.data_full = !s_reg.rd_mode;
        end
      endcase
    end

    // Write-side hand-off of the host byte into the FIFO
    if (!s_reg.rd_mode && fifo_in.valid && fifo_in.ready) begin
      s_next.data_full = 1'b0;
    end
    // Read-side: FIFO head loads the data register once it is empty
    if (s_reg.rd_mode && fifo_out.valid && fifo_out.ready) begin
      s_next.data = fifo_out.data;
      s_next.data_full = 1'b1;
    end
    if (s_reg.rd_mode && fifo_in.valid && fifo_in.ready) begin
      s_next.push_valid = 1'b0;
    end

    // Sequencer; only a forced interrupt is taken while busy
    unique case (s_reg.state)
      S_IDLE: begin
        if (host_cmd) begin
          s_next.cmd = i_host_wdata;
          s_next.st_wp = 1'b0;
          s_next.st_wf = 1'b0;
          s_next.st_lost = 1'b0;
          s_next.bytes = '0;
          s_next.asm_cnt = '0;
          s_next.push_valid = 1'b0;
          s_next.type1_last = 1'b0;
          k = cmd_kind(i_host_wdata);
          if (k == K_TYPE1) begin
            s_next.type1_last = 1'b1;
            s_next.timer = 9'(TYPE1_CYCLES);
            s_next.state = S_SEEK;
          end else if (k == K_FORCE_INT) begin
            done = 1'b1;
          end else if (k == K_WRITE_SECTOR || k == K_WRITE_TRACK) begin
            s_next.rd_mode = 1'b0;
            s_next.data_full = 1'b0;
            if (!i_write_protect_sense_n) begin
              s_next.st_wp = 1'b1;
              done = 1'b1;
            end else begin
              s_next.gate = 1'b1;
              s_next.timer = 9'(GATE_LEAD_CYCLES);
              s_next.state = S_GATE;
            end
          end else begin
            s_next.rd_mode = 1'b1;
            s_next.data_full = 1'b0;
            s_next.state = S_READ;
          end
        end
      end
      S_SEEK: begin
        // Ready is not looked at here
        if (s_reg.timer == 9'h001) begin
          done = 1'b1;
          if (s_reg.cmd[7:4] == 4'h0) begin
            s_next.track = 8'h00;
          end else if (s_reg.cmd[7:4] == 4'h1) begin
            s_next.track = s_reg.data;
          end else if (s_reg.cmd[4]) begin
            s_next.track = s_reg.cmd[6:5] == 2'h3 ? s_reg.track - 8'h01
                                                  : s_reg.track + 8'h01;
          end
        end else begin
          s_next.timer = s_reg.timer - 9'h001;
        end
      end
      S_READ: begin
        if (i_read_bit_strobe) begin
          s_next.asm_shift = {s_reg.asm_shift[6:0], i_read_bit};
          s_next.asm_cnt = s_reg.asm_cnt + 3'h1;
          if (s_reg.asm_cnt == 3'h7) begin
            // Disk cannot wait: a byte with nowhere to go is lost
            if (s_next.push_valid) begin
              s_next.st_lost = 1'b1;
            end else begin
              s_next.push_valid = 1'b1;
              s_next.push_data = {s_reg.asm_shift[6:0], i_read_bit};
            end
            s_next.bytes = s_reg.bytes + 9'h001;
            if (k != K_READ_TRACK && s_reg.bytes + 9'h001 == target) begin
              done = 1'b1;
            end
          end
        end
        if (k == K_READ_TRACK && idx_edge) begin
          done = 1'b1;
        end
      end
      S_GATE: begin
        if (s_reg.timer == 9'h001) begin
          s_next.state = S_WRITE;
          s_next.timer = '0;
          s_next.sh_valid = 1'b0;
        end else begin
          s_next.timer = s_reg.timer - 9'h001;
        end
      end
      S_WRITE: begin
        if (!s_reg.sh_valid) begin
          // Underrun writes a zero byte and flags lost data
          s_next.shift = fifo_out.valid ? fifo_out.data : 8'h00;
          s_next.st_lost = s_reg.st_lost | !fifo_out.valid;
          s_next.sh_valid = 1'b1;
          s_next.bitcnt = '0;
          s_next.phase = 1'b0;
          s_next.timer = '0;
        end else if (s_reg.timer == half - 9'h001) begin
          s_next.timer = '0;
          s_next.phase = !s_reg.phase;
          if (!s_reg.phase) begin
            // Clock slot: always in single, only between zeros in double
            s_next.pulse = i_density_select ||
                           (!s_reg.prev_bit && !s_reg.shift[7]);
          end else begin
            s_next.pulse = s_reg.shift[7];
            s_next.prev_bit = s_reg.shift[7];
            s_next.shift = {s_reg.shift[6:0], 1'b0};
            s_next.bitcnt = s_reg.bitcnt + 3'h1;
            if (s_reg.bitcnt == 3'h7) begin
              s_next.sh_valid = 1'b0;
              s_next.bytes = s_reg.bytes + 9'h001;
              if (k == K_WRITE_SECTOR &&
                  s_reg.bytes + 9'h001 == 9'(SECTOR_BYTES)) begin
                done = 1'b1;
              end
            end
          end
        end else begin
          s_next.timer = s_reg.timer + 9'h001;
        end
        if (k == K_WRITE_TRACK && idx_edge) begin
          done = 1'b1;
        end
      end
    endcase

    // Faults during transfers; the shared pin is taken as a fault only while gate is on
    if (s_reg.state == S_READ || s_reg.state == S_GATE ||
        s_reg.state == S_WRITE) begin
      if (!i_ready) begin
        done = 1'b1;
      end
      if (s_reg.gate && !i_fault_in_vfo_enable_n) begin
        s_next.st_wf = 1'b1;
        done = 1'b1;
      end
    end
    if (s_reg.state != S_IDLE && host_cmd &&
        cmd_kind(i_host_wdata) == K_FORCE_INT) begin
      s_next.cmd = i_host_wdata;
      done = 1'b1;
    end

    // Completion or termination; the set wins over a same-cycle clear
    if (done) begin
      s_next.state = S_IDLE;
      s_next.gate = 1'b0;
      s_next.sh_valid = 1'b0;
      s_next.irq = 1'b1;
    end

    // Registered pin images
    s_next.drq = s_next.rd_mode ? s_next.data_full
               : (s_next.state != S_IDLE && !s_next.data_full);
    s_next.otk = (s_next.state == S_READ || s_next.state == S_WRITE) &&
                 s_next.track >= OUTER_TRACK_FIRST &&
                 s_next.track <= OUTER_TRACK_LAST;
    s_next.vfo_oe_n = !(s_next.state == S_READ && !s_next.gate);

    if (!i_resetn) begin
      s_next = '0;
      s_next.state = S_IDLE;
      s_next.cmd = CMD_RESET;
      s_next.sector = SECTOR_RESET;
      s_next.rd_mode = 1'b1;
      s_next.vfo_oe_n = 1'b1;
      s_next.idx_prev = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_host_rdata = s_reg.rdata;
  assign o_data_request = s_reg.drq;
  assign o_interrupt_request = s_reg.irq;
  assign o_outer_track_indicator = s_reg.otk;
  assign o_write_gate = s_reg.gate;
  assign o_write_pulse_out = s_reg.pulse;
  // Open drain: pulled low as the active VFO enable level
  assign o_fault_in_vfo_enable_n = 1'b0;
  assign o_fault_in_vfo_enable_oe_n = s_reg.vfo_oe_n;
endmodule

// ===== verif/fdhs_drive_model.sv
`timescale 1ns/1ps
module fdhs_drive_model (
  input wire logic i_clock,
  input wire logic i_gate,
  input wire logic i_vfo_oe_n,
  input wire logic i_vfo_n,
  input wire logic i_fault,
  input wire logic i_rdy,
  input wire logic i_wp,
  input wire logic i_tz,
  input wire logic i_idx,
  input wire logic i_send,
  input wire logic [7:0] i_byte,
  output logic o_ready,
  output logic o_pin_n,
  output logic o_tz_n,
  output logic o_idx_n,
  output logic o_wp_n,
  output logic o_stb,
  output logic o_bit
);
  logic [7:0] sh;
  logic [5:0] cnt;
  // Any low driver wins over the pull-up; a fault is only driven while the gate is on
  assign o_pin_n = !((!i_vfo_oe_n && !i_vfo_n) || (i_gate && i_fault));
  assign o_ready = i_rdy;
  assign o_tz_n = !i_tz;
  assign o_idx_n = !i_idx;
  assign o_wp_n = !i_wp;
  initial begin
    cnt = 6'h00;
    sh = 8'h00;
    o_stb = 1'b0;
    o_bit = 1'b0;
  end
  // MSB first, a strobe every fourth cycle; the bit line wanders between
  always @(posedge i_clock) begin
    o_stb <= 1'b0;
    o_bit <= !o_bit;
    if (i_send && cnt == 6'h00) begin
      sh <= i_byte;
      cnt <= 6'h20;
    end else if (cnt != 6'h00) begin
      cnt <= cnt - 6'h01;
      if (cnt[1:0] == 2'h0) begin
        o_stb <= 1'b1;
        o_bit <= sh[7];
        sh <= {sh[6:0], 1'b0};
      end
    end
  end
endmodule

// ===== verif/fdhs_top_chk.sv
`timescale 1ns/1ps
module fdhs_top_chk (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_rd_strobe,
  input wire logic i_wr_strobe,
  input wire logic [1:0] i_reg_sel,
  input wire logic [7:0] o_host_rdata,
  input wire logic o_data_request,
  input wire logic o_interrupt_request,
  input wire logic o_write_gate,
  input wire logic o_write_pulse_out,
  input wire logic i_ready,
  input wire logic i_fault_in_vfo_enable_n,
  input wire logic o_fault_in_vfo_enable_oe_n
);
  import fdhs_pkg::*;
  logic clr;
  // Status read or command write
  assign clr = (i_rd_strobe || i_wr_strobe) && i_reg_sel == SEL_STATUS_CMD;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  property p_gate_lead;
    $rose(o_write_pulse_out) |-> $past(o_write_gate);
  endproperty
  a_gate_lead: assert property (p_gate_lead) else $error("pulse without gate");
  property p_pulse_one;
    o_write_pulse_out |=> !o_write_pulse_out;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("long pulse");
  property p_rdy_abort;
    o_write_gate && !i_ready |=> o_interrupt_request;
  endproperty
  a_rdy_abort: assert property (p_rdy_abort) else $error("no abort");
  property p_not_ready;
    i_rd_strobe && i_reg_sel == SEL_STATUS_CMD
      |=> o_host_rdata[ST_NOT_READY] == !$past(i_ready);
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("bad NR bit");
  property p_vfo_dir;
    !o_fault_in_vfo_enable_oe_n |-> !o_write_gate;
  endproperty
  a_vfo_dir: assert property (p_vfo_dir) else $error("vfo with gate");
  property p_fault;
    o_write_gate && !i_fault_in_vfo_enable_n
      |=> o_interrupt_request && !o_write_gate;
  endproperty
  a_fault: assert property (p_fault) else $error("fault ignored");
  property p_drq_clr;
    (i_rd_strobe || i_wr_strobe) && i_reg_sel == SEL_DATA |=> !o_data_request;
  endproperty
  a_drq_clr: assert property (p_drq_clr) else $error("drq kept");
  property p_irq_clr;
    $fell(o_interrupt_request) |-> $past(clr);
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq lost");
  property p_irq_hold;
    o_interrupt_request && !clr |=> o_interrupt_request;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule
bind fdhs_top fdhs_top_chk u_chk (.i_clock, .i_resetn, .i_rd_strobe,
  .i_wr_strobe, .i_reg_sel, .o_host_rdata, .o_data_request,
  .o_interrupt_request, .o_write_gate, .o_write_pulse_out, .i_ready,
  .i_fault_in_vfo_enable_n, .o_fault_in_vfo_enable_oe_n);

// ===== verif/fdhs_top_test.sv
`timescale 1ns/1ps
module fdhs_top_test;
  import fdhs_pkg::*;
  logic i_clock, i_resetn, i_rd_strobe, i_wr_strobe, i_density_select;
  logic [1:0] i_reg_sel;
  logic [7:0] i_host_wdata, o_host_rdata, got, sbyte;
  logic o_data_request, o_interrupt_request, o_outer_track_indicator;
  logic o_write_gate, o_write_pulse_out, i_ready, i_fault_in_vfo_enable_n;
  logic o_fault_in_vfo_enable_n, o_fault_in_vfo_enable_oe_n;
  logic i_track_zero_sense_n, i_index_hole_sense_n, i_write_protect_sense_n;
  logic i_read_bit_strobe, i_read_bit, flt, rdy, wp, send, tz, idx;
  int mismatches, num_checks;
  fdhs_top #(.FIFO_DEPTH(8)) dut (.i_clock, .i_resetn, .i_rd_strobe,
    .i_wr_strobe, .i_reg_sel, .i_host_wdata, .o_host_rdata, .o_data_request,
    .o_interrupt_request, .o_outer_track_indicator, .o_write_gate,
    .o_write_pulse_out, .i_ready, .i_fault_in_vfo_enable_n,
    .o_fault_in_vfo_enable_n, .o_fault_in_vfo_enable_oe_n,
    .i_track_zero_sense_n, .i_index_hole_sense_n, .i_write_protect_sense_n,
    .i_density_select, .i_read_bit_strobe, .i_read_bit);
  fdhs_drive_model drv (.i_clock(i_clock), .i_gate(o_write_gate),
    .i_vfo_oe_n(o_fault_in_vfo_enable_oe_n),
    .i_vfo_n(o_fault_in_vfo_enable_n), .i_fault(flt), .i_rdy(rdy),
    .i_wp(wp), .i_tz(tz), .i_idx(idx), .i_send(send), .i_byte(sbyte),
    .o_ready(i_ready), .o_pin_n(i_fault_in_vfo_enable_n),
    .o_tz_n(i_track_zero_sense_n), .o_idx_n(i_index_hole_sense_n),
    .o_wp_n(i_write_protect_sense_n), .o_stb(i_read_bit_strobe),
    .o_bit(i_read_bit));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  // One-cycle strobes; flags settle one cycle after the strobe edge
  task automatic hw(input logic [1:0] s, input logic [7:0] d);
    @(posedge i_clock);
    i_wr_strobe <= 1'b1;
    i_reg_sel <= s;
    i_host_wdata <= d;
    @(posedge i_clock);
    i_wr_strobe <= 1'b0;
    #1;
  endtask
  task automatic hr(input logic [1:0] s);
    @(posedge i_clock);
    i_rd_strobe <= 1'b1;
    i_reg_sel <= s;
    @(posedge i_clock);
    i_rd_strobe <= 1'b0;
    #1;
    got = o_host_rdata;
  endtask
  task automatic wait_irq(input int n);
    repeat (n) begin
      if (o_interrupt_request === 1'b1) break;
      @(posedge i_clock);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    repeat (300) @(posedge i_clock);
    hr(SEL_STATUS_CMD);
    hw(SEL_TRACK, 8'h05);
    hw(SEL_SECTOR, 8'h3C);
    hr(SEL_TRACK);
    chk(got, 8'h05);
    hr(SEL_SECTOR);
    chk(got, 8'h3C);
  endtask
  task automatic t_seek();
    rdy <= 1'b0;
    hr(SEL_STATUS_CMD);
    chk1(got[ST_NOT_READY], 1'b1);
    hw(SEL_DATA, 8'h2D);
    hw(SEL_STATUS_CMD, 8'h10);
    wait_irq(300);
    chk1(o_interrupt_request, 1'b1);
    hr(SEL_TRACK);
    chk(got, 8'h2D);
    rdy <= 1'b1;
    tz <= 1'b1;
    hr(SEL_STATUS_CMD);
    chk1(got[ST_NOT_READY], 1'b0);
    chk1(got[ST_TRACK_ZERO], 1'b1);
    chk1(o_interrupt_request, 1'b0);
    tz <= 1'b0;
  endtask
  task automatic t_wprot();
    wp <= 1'b1;
    hw(SEL_STATUS_CMD, 8'hA0);
    wait_irq(10);
    chk1(o_interrupt_request, 1'b1);
    chk1(o_write_gate, 1'b0);
    hr(SEL_STATUS_CMD);
    chk1(got[ST_WRITE_PROT], 1'b1);
    wp <= 1'b0;
  endtask
  // Single density zeros: clock pulses only, a whole cell apart
  task automatic t_write();
    int n, last, gap;
    n = 0;
    last = -1;
    gap = 100000;
    i_density_select <= 1'b1;
    hw(SEL_STATUS_CMD, 8'hA0);
    chk1(o_write_gate, 1'b1);
    chk1(o_data_request, 1'b1);
    hw(SEL_DATA, 8'h00);
    chk1(o_data_request, 1'b0);
    for (int k = 0; k < 1700; k++) begin
      @(posedge i_clock);
      #1;
      if (o_write_pulse_out === 1'b1) begin
        if (last >= 0 && k - last < gap) gap = k - last;
        last = k;
        n++;
      end
    end
    chk1(n > 2, 1'b1);
    chk1(gap == 2 * SD_HALF_CYCLES, 1'b1);
    chk1(o_outer_track_indicator, 1'b1);
    flt <= 1'b1;
    wait_irq(5);
    chk1(o_interrupt_request, 1'b1);
    chk1(o_write_gate, 1'b0);
    flt <= 1'b0;
    hr(SEL_STATUS_CMD);
    chk1(got[ST_WRITE_FAULT], 1'b1);
    i_density_select <= 1'b0;
  endtask
  task automatic t_read();
    hw(SEL_STATUS_CMD, 8'h80);
    chk1(o_fault_in_vfo_enable_oe_n, 1'b0);
    sbyte <= 8'hA5;
    send <= 1'b1;
    @(posedge i_clock);
    send <= 1'b0;
    repeat (60) begin
      @(posedge i_clock);
      #1;
      if (o_data_request === 1'b1) break;
    end
    chk1(o_data_request, 1'b1);
    chk1(o_outer_track_indicator, 1'b1);
    hr(SEL_DATA);
    chk(got, 8'hA5);
    chk1(o_data_request, 1'b0);
    rdy <= 1'b0;
    wait_irq(5);
    chk1(o_interrupt_request, 1'b1);
    rdy <= 1'b1;
    hr(SEL_STATUS_CMD);
  endtask
  // Forced end of a busy read, ready loss while gated, index ends a track
  task automatic t_force();
    hw(SEL_STATUS_CMD, 8'h80);
    hw(SEL_STATUS_CMD, 8'hD0);
    chk1(o_interrupt_request, 1'b1);
    chk1(o_fault_in_vfo_enable_oe_n, 1'b1);
    chk1(o_fault_in_vfo_enable_n, 1'b0);
    hr(SEL_STATUS_CMD);
    hw(SEL_STATUS_CMD, 8'hA0);
    rdy <= 1'b0;
    wait_irq(5);
    chk1(o_interrupt_request, 1'b1);
    chk1(o_write_gate, 1'b0);
    rdy <= 1'b1;
    hr(SEL_STATUS_CMD);
    hw(SEL_STATUS_CMD, 8'hE0);
    idx <= 1'b1;
    wait_irq(5);
    chk1(o_interrupt_request, 1'b1);
    idx <= 1'b0;
    hr(SEL_STATUS_CMD);
    chk1(got[ST_BUSY], 1'b0);
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = !i_clock;
  end
  // Whole sequence needs well under 5000 cycles
  initial begin
    #300000;
    mismatches++;
    finish_test();
  end
  initial begin
    {i_rd_strobe, i_wr_strobe, i_density_select, flt, wp, send} = 6'h00;
    {tz, idx} = 2'h0;
    i_resetn = 1'b0;
    rdy = 1'b1;
    i_reg_sel = 2'h0;
    i_host_wdata = 8'h00;
    sbyte = 8'h00;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_regs();
    t_seek();
    t_wprot();
    t_write();
    t_read();
    t_force();
    finish_test();
  end
endmodule
